/* logic/serial_core_consts.vh */
// Register offsets, field positions, reset values and timing counts for the serial core
`ifndef SERIAL_CORE_CONSTS_VH
`define SERIAL_CORE_CONSTS_VH

// --------
// Register word offsets (address bits 3:2)
// --------
`define OFS_CONTROL_ZERO 2'h0
`define OFS_CONTROL_ONE 2'h1
`define OFS_STATUS 2'h2
`define OFS_DATA 2'h3

// --------
// Control one fields
// --------
`define C1_SEND_BREAK 0
`define C1_RX_ENABLE 2
`define C1_TX_ENABLE 3
`define C1_IDLE_IRQ_EN 4
`define C1_RX_FULL_IRQ_EN 5
`define C1_TX_COMPLETE_IRQ_EN 6
`define C1_TX_EMPTY_IRQ_EN 7
`define C1_FRAME_LENGTH 9
`define C1_PARITY_ENABLE 10
`define C1_PARITY_TYPE 11
`define C1_WIRED_OR_MODE 14
`define C1_WRITE_MASK 16'h4efd

// --------
// Status fields
// --------
`define ST_TX_EMPTY 8
`define ST_TX_COMPLETE 7
`define ST_RX_FULL 6
`define ST_IDLE 4
`define ST_OVERRUN 3
`define ST_PARITY_ERROR 0
`define ST_RESET 9'h180

// --------
// Widths and counts
// --------
`define DIVISOR_WIDTH 13
`define TICKS_PER_BIT 4'hf
`define MID_BIT 4'h8
`define START_ONES 2'h3

`endif

/* logic/async_serial_transmit_core.v */
// Serial transmitter core with minimal receiver, baud divider and Avalon-MM register slave
`timescale 1ns/1ps
`include "serial_core_consts.vh"

// Summary of operation
// - Interrupt only for enabled flags; flags always update
// - Start needs three one samples then falling
// - Ten or eleven bit frames by length bit
// - Data goes LSB first after start bit
// - Modulus divider gives clock over 32 times divisor
// - Divisor zero stops all sampling ticks
// - Sixteen times sampling, realigned on line transitions
// - Parity type zero even, one odd
// - Parity before stop; error flag judged one shift early, without the parity sample
// - Data width from length and parity bits
// - Shifter owns pin while enabled or busy
// - Wired-or bit makes pin open drain
// - Data write overwrites buffer, clears empty flag
// - Buffer moves to shifter, empty flag sets
// - Complete flag clears by status read, write
// - Enable sends idle preamble, then complete
// - Break frames repeat while break bit set
// - After break, unless data or preamble queued, mark one bit, set complete
// - Idle enabled: flags set, pin held high
// - Disable finishes frames, discards buffer, releases pin
// - Re-enable during frame queues mark preamble
// - Low data byte access clears armed flags, armed complete only on a write
// - Status read arms only flags set then
module async_serial_transmit_core (
    input wire mclk,
    input wire rst,
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    input wire rxIn,
    input wire portTxLevel,
    input wire portDirection,
    output reg txOut,
    output reg txOe,
    output reg irq
);

    // --------
    // Helper functions
    // --------
    // Byte-lane merge for the low half word of a register
    function [15:0] mergeLanes;
        input [15:0] old;
        input [15:0] nw;
        input [1:0] be;
        begin
            mergeLanes = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    // Build a frame LSB first: start, data, optional parity, stop ones above
    function [10:0] makeFrame;
        input [8:0] d;
        input m;
        input pe;
        input pt;
        begin
            case ({m, pe})
                2'b00: makeFrame = {2'b11, d[7:0], 1'b0};
                2'b01: makeFrame = {2'b11, (^d[6:0]) ^ pt, d[6:0], 1'b0};
                2'b10: makeFrame = {1'b1, d[8:0], 1'b0};
                default: makeFrame = {1'b1, (^d[7:0]) ^ pt, d[7:0], 1'b0};
            endcase
        end
    endfunction

    // --------
    // Registers and state
    // --------
    localparam TX_IDLE = 3'h0;
    localparam TX_DATA = 3'h1;
    localparam TX_PREAMBLE = 3'h2;
    localparam TX_BREAK = 3'h3;
    localparam TX_MARK = 3'h4;
    localparam RX_IDLE = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_BITS = 2'h2;

    reg [`DIVISOR_WIDTH-1:0] baudDivisor;
    reg [15:0] controlOne;
    reg [8:0] status;
    reg [8:0] armMask;
    reg [8:0] snapshot;
    reg [8:0] transmitBuffer;
    reg [8:0] rxData;
    reg [`DIVISOR_WIDTH:0] divCount;
    reg tick;
    reg [3:0] txPhase;
    reg [2:0] txState;
    reg [10:0] txShift;
    reg [3:0] txLeft;
    reg preamblePending;
    reg rxMeta;
    reg rxSync;
    reg rxPrev;
    reg [1:0] rxState;
    reg [1:0] onesSeen;
    reg [3:0] rxPhase;
    reg [3:0] rxCount;
    reg [10:0] rxShift;
    reg [7:0] idleTicks;
    reg idleArmed;

    wire txEnable = controlOne[`C1_TX_ENABLE];
    wire frameLength = controlOne[`C1_FRAME_LENGTH];
    wire parityEnable = controlOne[`C1_PARITY_ENABLE];
    wire parityType = controlOne[`C1_PARITY_TYPE];
    wire [3:0] frameBits = frameLength ? 4'hb : 4'ha;
    wire busTake = (read | write) & ~waitrequest;
    wire dataAccess = busTake & (address[3:2] == `OFS_DATA) & byteenable[0];
    wire dataWrite = dataAccess & write;
    wire statusRead = busTake & read & (address[3:2] == `OFS_STATUS) & (byteenable[1:0] != 2'h0);
    wire c1Write = busTake & write & (address[3:2] == `OFS_CONTROL_ONE);
    wire [15:0] nextControlOne = (mergeLanes(controlOne, writedata[15:0], byteenable[1:0]) &
                                  `C1_WRITE_MASK);
    wire bitTick = tick & (txPhase == `TICKS_PER_BIT);
    wire frameDone = bitTick & (txLeft == 4'h1);
    wire txBusy = (txState != TX_IDLE);

    // --------
    // Avalon-MM slave handshake
    // --------
    // Waitrequest drops one cycle after the request so readdata comes from a flop
    always @(posedge mclk) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
            snapshot <= 9'h0;
        end else if ((read | write) & waitrequest) begin
            waitrequest <= 1'b0;
            snapshot <= status;
            case (address[3:2])
                `OFS_CONTROL_ZERO: readdata <= {19'h0, baudDivisor};
                `OFS_CONTROL_ONE: readdata <= {16'h0, controlOne};
                `OFS_STATUS: readdata <= {23'h0, status};
                default: readdata <= {23'h0, rxData};
            endcase
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // --------
    // Control registers
    // --------
    wire [15:0] nextDivisor = mergeLanes({3'h0, baudDivisor}, writedata[15:0], byteenable[1:0]);
    always @(posedge mclk) begin
        if (rst) begin
            baudDivisor <= {`DIVISOR_WIDTH{1'b0}};
            controlOne <= 16'h0;
        end else if (busTake & write & (address[3:2] == `OFS_CONTROL_ZERO)) begin
            baudDivisor <= nextDivisor[`DIVISOR_WIDTH-1:0];
        end else if (c1Write) begin
            controlOne <= nextControlOne;
        end
    end

    // --------
    // Baud divider
    // --------
    // Counts twice the divisor per tick: sixteen ticks per bit gives fsys / (32 x divisor)
    always @(posedge mclk) begin
        if (rst || baudDivisor == {`DIVISOR_WIDTH{1'b0}}) begin
            divCount <= {(`DIVISOR_WIDTH+1){1'b0}};
            tick <= 1'b0;
        end else if (divCount >= {baudDivisor, 1'b0} - 1'b1) begin
            divCount <= {(`DIVISOR_WIDTH+1){1'b0}};
            tick <= 1'b1;
        end else begin
            divCount <= divCount + 1'b1;
            tick <= 1'b0;
        end
    end

    // --------
    // Transmit sequencer
    // --------
    // A frame boundary (or idle) picks the next frame: break, preamble, data, mark, idle
    always @(posedge mclk) begin
        if (rst) begin
            txState <= TX_IDLE;
            txShift <= 11'h7ff;
            txLeft <= 4'h0;
            txPhase <= 4'h0;
            preamblePending <= 1'b0;
        end else begin
            if (tick) begin
                txPhase <= txPhase + 1'b1;
            end
            if (c1Write & nextControlOne[`C1_TX_ENABLE] & ~txEnable) begin
                // Busy shifter or not, a cycle of disable and enable queues a preamble
                preamblePending <= 1'b1;
            end
            if (bitTick & (txLeft > 4'h1)) begin
                txShift <= {1'b1, txShift[10:1]};
                txLeft <= txLeft - 1'b1;
            end else if (frameDone | (~txBusy & tick)) begin
                if (~txBusy) begin
                    txPhase <= 4'h0;
                end
                if (txEnable & controlOne[`C1_SEND_BREAK]) begin
                    txState <= TX_BREAK;
                    txShift <= 11'h0;
                    txLeft <= frameBits;
                end else if (preamblePending) begin
                    txState <= TX_PREAMBLE;
                    txShift <= 11'h7ff;
                    txLeft <= frameBits;
                    preamblePending <= 1'b0;
                end else if (txEnable & ~status[`ST_TX_EMPTY]) begin
                    txState <= TX_DATA;
                    txShift <= makeFrame(transmitBuffer, frameLength, parityEnable, parityType);
                    txLeft <= frameBits;
                end else if (txState == TX_BREAK) begin
                    txState <= TX_MARK;
                    txShift <= 11'h7ff;
                    txLeft <= 4'h1;
                end else begin
                    txState <= TX_IDLE;
                    txShift <= 11'h7ff;
                    txLeft <= 4'h0;
                end
            end
        end
    end

    // Buffer loads on any low-byte data write, overwriting unsent data
    wire [15:0] nextBuffer = mergeLanes({7'h0, transmitBuffer}, writedata[15:0], byteenable[1:0]);
    always @(posedge mclk) begin
        if (rst) begin
            transmitBuffer <= 9'h0;
        end else if (dataWrite) begin
            transmitBuffer <= nextBuffer[8:0];
        end
    end

    // --------
    // Receiver
    // --------
    // Line passes two flops first; only the second is read by logic
    always @(posedge mclk) begin
        if (rst) begin
            rxMeta <= 1'b1;
            rxSync <= 1'b1;
        end else begin
            rxMeta <= rxIn;
            rxSync <= rxMeta;
        end
    end

    wire [10:0] rxFrame = frameLength ? rxShift : {1'b1, rxShift[10:1]};
    wire rxParityBad = parityEnable & (frameLength ? ((^rxFrame[9:1]) != parityType) :
                                                     ((^rxFrame[8:1]) != parityType));
    wire rxLast = tick & (rxState == RX_BITS) & (rxPhase == `MID_BIT) & (rxCount == frameBits - 1'b1);
    wire rxFullSet = rxLast & ~status[`ST_RX_FULL];
    wire idleSet = tick & (rxState == RX_IDLE) & idleArmed & (idleTicks == {frameBits, 4'h0});

    // Sampling at mid bit, phase reset on every transition keeps samples centred
    always @(posedge mclk) begin
        if (rst || ~controlOne[`C1_RX_ENABLE]) begin
            rxState <= RX_IDLE;
            rxPrev <= 1'b1;
            onesSeen <= 2'h0;
            rxPhase <= 4'h0;
            rxCount <= 4'h0;
            rxShift <= 11'h7ff;
            idleTicks <= 8'h0;
        end else if (tick) begin
            rxPrev <= rxSync;
            rxPhase <= (rxSync != rxPrev) ? 4'h1 : rxPhase + 1'b1;
            idleTicks <= (rxSync & (rxState == RX_IDLE) & (idleTicks != 8'hff)) ? idleTicks + 1'b1 : 8'h0;
            case (rxState)
                RX_IDLE: begin
                    if (rxSync) begin
                        onesSeen <= (onesSeen == `START_ONES) ? onesSeen : onesSeen + 1'b1;
                    end else if (rxPrev & (onesSeen == `START_ONES)) begin
                        rxState <= RX_START;
                        rxPhase <= 4'h1;
                    end else begin
                        onesSeen <= 2'h0;
                    end
                end
                RX_START: begin
                    if (rxPhase == `MID_BIT) begin
                        rxState <= rxSync ? RX_IDLE : RX_BITS;
                        onesSeen <= 2'h0;
                        rxCount <= 4'h1;
                        rxShift <= {10'h3ff, 1'b0};
                    end
                end
                RX_BITS: begin
                    if (rxPhase == `MID_BIT) begin
                        rxShift <= {rxSync, rxShift[10:1]};
                        rxCount <= rxCount + 1'b1;
                        if (rxLast) begin
                            rxState <= RX_IDLE;
                        end
                    end
                end
                default: rxState <= RX_IDLE;
            endcase
        end
    end

    // Received word kept for software; the frame completes one shift later
    reg rxDeliver;
    always @(posedge mclk) begin
        if (rst) begin
            rxDeliver <= 1'b0;
        end else begin
            rxDeliver <= rxFullSet;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            rxData <= 9'h0;
        end else if (rxDeliver) begin
            case ({frameLength, parityEnable})
                2'b00: rxData <= {1'b0, rxFrame[8:1]};
                2'b01: rxData <= {2'b0, rxFrame[7:1]};
                2'b10: rxData <= rxFrame[9:1];
                default: rxData <= {1'b0, rxFrame[8:1]};
            endcase
        end
    end

    // --------
    // Status flags
    // --------
    // Set beats clear: data access clears armed flags, armed complete only on a write; data write also clears empty, enable clears complete
    reg [8:0] setFlags;
    reg [8:0] clearFlags;
    always @* begin
        setFlags = 9'h0;
        clearFlags = 9'h0;
        setFlags[`ST_TX_EMPTY] = (frameDone | (~txBusy & tick)) & txEnable & ~controlOne[`C1_SEND_BREAK] &
                                 ~preamblePending & ~status[`ST_TX_EMPTY];
        setFlags[`ST_TX_EMPTY] = setFlags[`ST_TX_EMPTY] | (~txEnable & ~txBusy);
        setFlags[`ST_TX_COMPLETE] = txBusy & frameDone & (txState != TX_BREAK) &
                                    ~(txEnable & (controlOne[`C1_SEND_BREAK] | ~status[`ST_TX_EMPTY])) &
                                    ~preamblePending;
        setFlags[`ST_RX_FULL] = rxFullSet;
        setFlags[`ST_OVERRUN] = rxLast & status[`ST_RX_FULL];
        setFlags[`ST_PARITY_ERROR] = rxFullSet & rxParityBad;
        setFlags[`ST_IDLE] = idleSet;
        if (dataAccess) begin
            clearFlags = armMask;
        end
        if (dataWrite) begin
            clearFlags[`ST_TX_EMPTY] = 1'b1;
        end else begin
            clearFlags[`ST_TX_COMPLETE] = 1'b0;
        end
        if (c1Write & nextControlOne[`C1_TX_ENABLE] & ~txEnable) begin
            clearFlags[`ST_TX_COMPLETE] = 1'b1;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            status <= `ST_RESET;
            armMask <= 9'h0;
            idleArmed <= 1'b0;
        end else begin
            status <= (status & ~clearFlags) | setFlags;
            if (statusRead) begin
                armMask <= snapshot;
            end else if (dataAccess) begin
                armMask <= 9'h0;
            end
            if (rxFullSet) begin
                idleArmed <= 1'b1;
            end else if (idleSet) begin
                idleArmed <= 1'b0;
            end
        end
    end

    // --------
    // Pin and interrupt outputs
    // --------
    // Open drain drives only the low level; the pull-up makes the high
    wire ownPin = txEnable | txBusy;
    wire pinLevel = ownPin ? txShift[0] : portTxLevel;
    wire pinDriven = ownPin | portDirection;
    always @(posedge mclk) begin
        if (rst) begin
            txOut <= 1'b1;
            txOe <= 1'b0;
            irq <= 1'b0;
        end else begin
            txOut <= pinLevel;
            txOe <= pinDriven & (~controlOne[`C1_WIRED_OR_MODE] | ~pinLevel);
            irq <= (status[`ST_TX_EMPTY] & controlOne[`C1_TX_EMPTY_IRQ_EN]) |
                   (status[`ST_TX_COMPLETE] & controlOne[`C1_TX_COMPLETE_IRQ_EN]) |
                   (status[`ST_RX_FULL] & controlOne[`C1_RX_FULL_IRQ_EN]) |
                   (status[`ST_IDLE] & controlOne[`C1_IDLE_IRQ_EN]);
        end
    end

endmodule

/* tb/async_serial_transmit_core_properties.sv */
// Concurrent checks on the serial core's bus and pin ports
`timescale 1ns/1ps
`include "serial_core_consts.vh"
module async_serial_transmit_core_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic rxIn,
    input wire logic portTxLevel,
    input wire logic portDirection,
    input wire logic txOut,
    input wire logic txOe,
    input wire logic irq
);
    // --------
    // Shadow of software settings
    // --------
    logic [12:0] shDiv;
    logic [15:0] shCtl;
    logic [15:0] zeroRun;

    // Bench writes whole half words, so a plain shadow stays exact
    always @(posedge mclk) begin
        if (rst) begin
            shDiv <= 13'h0;
            shCtl <= 16'h0;
        end else if (write && !waitrequest) begin
            if (address[3:2] == 2'h0)
                shDiv <= writedata[12:0];
            if (address[3:2] == 2'h1)
                shCtl <= writedata[15:0];
        end
    end

    // Length of the current low run on the pin
    always @(posedge mclk) begin
        if (rst || txOut)
            zeroRun <= 16'h0;
        else
            zeroRun <= zeroRun + 16'h1;
    end

    // --------
    // Assertions
    // --------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low twice in a row");
    a_req_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered next cycle");
    a_reset_idle: assert property ($fell(rst) |-> waitrequest && !txOe && txOut && !irq)
        else $error("outputs wrong after reset");
    a_ctl_readback: assert property (read && !waitrequest && address[3:2] == 2'h1
        |-> readdata == {16'h0, shCtl & `C1_WRITE_MASK})
        else $error("control one readback wrong");
    a_status_width: assert property (read && !waitrequest && address[3:2] == 2'h2 |-> readdata[31:9] == 23'h0)
        else $error("status upper bits not zero");
    a_irq_gate: assert property (irq |-> shCtl[7:4] != 4'h0 || $past(shCtl[7:4]) != 4'h0)
        else $error("irq without enable");
    a_wired_or: assert property (shCtl[14] && $past(shCtl[14]) && txOe |-> !txOut)
        else $error("open drain pin driven high");
    a_bit_multiple: assert property (shCtl[3] && shDiv == 13'h1 && $rose(txOut)
        |-> zeroRun[4:0] == 5'h0 && zeroRun != 16'h0)
        else $error("low run not whole bit times");
    a_div_stop: assert property (shCtl[3] && shDiv == 13'h0 && $past(shDiv) == 13'h0 |-> txOut)
        else $error("pin moved with divisor zero");

    c_frame_edge: cover property (shCtl[3] && $rose(txOut));
    c_irq: cover property (irq);
    c_data_read: cover property (read && !waitrequest && address[3:2] == 2'h3);
endmodule

bind async_serial_transmit_core async_serial_transmit_core_checker chk (.*);

/* tb/remote_serial_peer.sv */
// Remote serial peer: frame receiver on the line, frame sender on rxIn
`timescale 1ns/1ps
module remote_serial_peer #(
    parameter BITLEN = 32
) (
    input wire logic mclk,
    input wire logic lineIn,
    input wire logic [3:0] frameBits,
    output logic rxLine,
    output logic [10:0] frame,
    output integer frames
);
    // --------
    // Frame capture
    // --------
    logic busy;
    logic lastLine;
    logic [10:0] shift;
    integer cnt;

    initial begin
        busy = 1'b0;
        lastLine = 1'b1;
        rxLine = 1'b1;
        frames = 0;
        frame = 11'h0;
        cnt = 0;
    end

    // Start on a falling edge, sample mid-bit; no stop check so breaks count
    always @(posedge mclk) begin
        lastLine <= lineIn;
        if (!busy) begin
            if (lastLine === 1'b1 && lineIn === 1'b0) begin
                busy <= 1'b1;
                cnt <= 1;
                shift = 11'h0;
            end
        end else begin
            cnt <= cnt + 1;
            if (cnt % BITLEN == BITLEN / 2) begin
                shift[cnt / BITLEN] = lineIn;
                if (cnt / BITLEN == frameBits - 1) begin
                    frame <= shift;
                    frames <= frames + 1;
                    busy <= 1'b0;
                end
            end
        end
    end

    // Send a frame first bit first, mark afterwards
    task send(input logic [10:0] fr, input integer n);
        integer k;
        begin
            for (k = 0; k < n; k++) begin
                @(posedge mclk);
                rxLine <= fr[k];
                repeat (BITLEN - 1) @(posedge mclk);
            end
            @(posedge mclk);
            rxLine <= 1'b1;
        end
    endtask
endmodule

/* tb/test_async_serial_transmit_core.sv */
// Self-checking bench for the serial transmit core
`timescale 1ns/1ps
module test_async_serial_transmit_core;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] address = 4'h0;
    logic [3:0] byteenable = 4'hf;
    logic read = 1'b0;
    logic write = 1'b0;
    logic portTxLevel = 1'b1;
    logic portDirection = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic [31:0] q;
    logic waitrequest, rxIn, txOut, txOe, irq;
    logic [3:0] frameBits = 4'ha;
    logic [10:0] frame;
    integer frames, n, i;
    integer badCount = 0;
    integer checks = 0;
    // Pull-up on the line covers release and open drain
    wire txLine = !(txOe === 1'b1 && txOut === 1'b0);

    async_serial_transmit_core uut (.mclk(mclk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .rxIn(rxIn), .portTxLevel(portTxLevel),
        .portDirection(portDirection), .txOut(txOut), .txOe(txOe), .irq(irq));
    remote_serial_peer #(.BITLEN(32)) peer (.mclk(mclk), .lineIn(txLine), .frameBits(frameBits),
        .rxLine(rxIn), .frame(frame), .frames(frames));

    // --------
    // Shared tasks
    // --------
    task end_sim;
        begin
            if (badCount == 0 && checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        begin
            checks++;
            if (got !== exp) begin
                badCount++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Hold the request until waitrequest is sampled low
    task bus(input logic rd, input logic [3:0] a, input logic [15:0] d);
        begin
            @(posedge mclk);
            address <= a;
            writedata <= {16'h0, d};
            read <= rd;
            write <= !rd;
            do
                @(posedge mclk);
            while (waitrequest !== 1'b0);
            q = readdata;
            read <= 1'b0;
            write <= 1'b0;
        end
    endtask

    task wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b0, a, d);
    endtask

    task waitFrames(input integer m);
        while (frames < m)
            @(posedge mclk);
    endtask

    function automatic logic [31:0] expFrame(input logic [8:0] d, input logic m, input logic pe, input logic pt);
        integer nd, k;
        logic [10:0] fr;
        begin
            nd = 8 + int'(m) - int'(pe);
            fr = 11'h0;
            for (k = 0; k < nd; k++)
                fr[k + 1] = d[k];
            if (pe)
                fr[nd + 1] = (^(d & ((9'h1 << nd) - 9'h1))) ^ pt;
            fr[nd + 1 + int'(pe)] = 1'b1;
            expFrame = {21'h0, fr};
        end
    endfunction

    // --------
    // Scenarios
    // --------
    task t_regs;
        begin
            bus(1'b1, 4'h8, 16'h0);
            cmp(q, 32'h180);
            cmp({30'h0, txOe, txOut}, 32'h1);
            wr(4'h4, 16'h4ef4);
            bus(1'b1, 4'h4, 16'h0);
            cmp(q, 32'h4ef4);
            repeat (3) @(posedge mclk);
            cmp({31'h0, irq}, 32'h1);
            wr(4'h4, 16'h0);
            repeat (3) @(posedge mclk);
            cmp({31'h0, irq}, 32'h0);
        end
    endtask

    // Divisor zero first, then every length, parity enable and type
    task t_formats;
        begin
            wr(4'h4, 16'h0008);
            wr(4'hc, 16'h00a5);
            repeat (400) @(posedge mclk);
            cmp(frames, 0);
            wr(4'h0, 16'h0001);
            waitFrames(1);
            cmp({21'h0, frame}, expFrame(9'h0a5, 1'b0, 1'b0, 1'b0));
            for (i = 0; i < 8; i++) begin
                repeat (40) @(posedge mclk);
                frameBits <= i[0] ? 4'hb : 4'ha;
                wr(4'h4, {4'h0, i[2], i[1], i[0], 9'h008});
                wr(4'hc, 16'h01a5 ^ {13'h0, i[2:0]});
                waitFrames(i + 2);
                cmp({21'h0, frame}, expFrame(9'h1a5 ^ {6'h0, i[2:0]}, i[0], i[1], i[2]));
            end
            repeat (40) @(posedge mclk);
            frameBits <= 4'ha;
            wr(4'h4, 16'h0008);
        end
    endtask

    task t_overwrite;
        begin
            n = frames;
            bus(1'b1, 4'h8, 16'h0);
            wr(4'hc, 16'h0011);
            bus(1'b1, 4'h8, 16'h0);
            cmp(q & 32'h80, 32'h0);
            wr(4'hc, 16'h0022);
            wr(4'hc, 16'h0033);
            bus(1'b1, 4'h8, 16'h0);
            cmp(q & 32'h100, 32'h0);
            waitFrames(n + 1);
            cmp({21'h0, frame}, expFrame(9'h011, 1'b0, 1'b0, 1'b0));
            waitFrames(n + 2);
            cmp({21'h0, frame}, expFrame(9'h033, 1'b0, 1'b0, 1'b0));
            repeat (100) @(posedge mclk);
            bus(1'b1, 4'h8, 16'h0);
            cmp(q & 32'h180, 32'h180);
            cmp({31'h0, txOut}, 32'h1);
        end
    endtask

    task t_break;
        begin
            n = frames;
            wr(4'h4, 16'h0009);
            waitFrames(n + 1);
            cmp({21'h0, frame}, 32'h0);
            wr(4'h4, 16'h0008);
            repeat (800) @(posedge mclk);
            bus(1'b1, 4'h8, 16'h0);
            cmp(q & 32'h180, 32'h180);
            cmp({31'h0, txOut}, 32'h1);
        end
    endtask

    // Disable with a frame still buffered: the buffered one is dropped
    task t_disable;
        begin
            n = frames;
            wr(4'hc, 16'h0044);
            repeat (40) @(posedge mclk);
            wr(4'hc, 16'h0055);
            wr(4'h4, 16'h0000);
            repeat (1000) @(posedge mclk);
            cmp(frames, n + 1);
            cmp({21'h0, frame}, expFrame(9'h044, 1'b0, 1'b0, 1'b0));
            cmp({31'h0, txOe}, 32'h0);
        end
    endtask

    task t_port;
        begin
            portDirection <= 1'b1;
            portTxLevel <= 1'b0;
            repeat (4) @(posedge mclk);
            cmp({30'h0, txOe, txOut}, 32'h2);
            wr(4'h4, 16'h4000);
            portTxLevel <= 1'b1;
            repeat (4) @(posedge mclk);
            cmp({31'h0, txOe}, 32'h0);
            portTxLevel <= 1'b0;
            repeat (4) @(posedge mclk);
            cmp({30'h0, txOe, txOut}, 32'h2);
            portDirection <= 1'b0;
            portTxLevel <= 1'b1;
            wr(4'h4, 16'h0008);
            repeat (4) @(posedge mclk);
            cmp({30'h0, txOe, txOut}, 32'h3);
            wr(4'h4, 16'h0000);
        end
    endtask

    task t_receive;
        begin
            wr(4'h4, 16'h0004);
            repeat (100) @(posedge mclk);
            peer.send({2'b01, 8'h3c, 1'b0}, 10);
            repeat (100) @(posedge mclk);
            bus(1'b1, 4'h8, 16'h0);
            cmp(q & 32'h40, 32'h40);
            bus(1'b1, 4'hc, 16'h0);
            cmp(q & 32'hff, 32'h3c);
        end
    endtask

    // --------
    // Clock, watchdog and main sequence
    // --------
    initial begin
        forever #4 mclk = ~mclk;
    end

    // Whole run is near 7500 cycles; eight times that means a hang
    initial begin
        repeat (60000) @(posedge mclk);
        badCount++;
        end_sim;
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_formats;
        t_overwrite;
        t_break;
        t_disable;
        t_port;
        t_receive;
        end_sim;
    end
endmodule
